// file: core/bdi_top.sv
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "bdi_cfg.svh"
// Overview of operation
// RULE1 - receiver works only in full-operation and listen-only modes
// RULE2 - non-low-power: receive output high for Data_1 or Idle, low for Data_0
// RULE3 - low-power modes ignore transmit data and transmit gate
// RULE4 - standby and sleep: receive and activity outputs low while wake flag set
// RULE5 - io supply loss forces activity low and guardian gate to default
// RULE6 - guardian gate low disables the transmitter regardless of other inputs
// RULE7 - guardian gate only matters in full-operation mode
// RULE8 - full operation, gate low, guardian high: send transmit bit; otherwise Idle
// RULE9 - non-low-power: activity high while bus Idle, low during data
// RULE10 - io supply loss forces fault low and mode selects to defaults
// RULE11 - mode selects pass a filter before the mode machine
// RULE12 - decode select pair into full, listen, sleep entry then sleep, standby
// RULE13 - wake detection runs in every mode
// RULE14 - wake inputs filtered against glitches and floating levels
// RULE15 - all supplies monitored, undervoltage reported on fault output
// RULE16 - bus data compared to transmit data, mismatch flagged as bus failure
// RULE17 - comparison runs only in full-operation mode
// RULE18 - host can read the status shift register
// RULE19 - unconnected inputs default: tx low, gate high, guardian low, selects low
// RULE20 - controller keeps transmit data low when asserting the transmit gate
// RULE21 - selects must stay stable for the filter time or mode is kept
// RULE22 - all digital inputs synchronised before use
// RULE23 - reset holds mode and status at standby default
module bdi_top
   import bdi_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic txData,
   input wire logic transmitGateLow,
   input wire logic guardianGate,
   input wire logic standbySelectLow,
   input wire logic modeSelect,
   input wire logic busIdle,
   input wire logic busData,
   input wire logic wakeLocal,
   input wire logic wakeRemote,
   input wire logic ioSupplyOk,
   input wire logic vbatOk,
   input wire logic vccOk,
   output logic rxDataOut,
   output logic activityLowOut,
   output logic faultLowOut,
   output logic regulatorControlOut,
   output logic busDriveEn,
   output logic busDriveData,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import bdi_pkg::*;

   localparam logic [7:0] FILT = 8'(`BDI_FILT_CYC);
   localparam logic [7:0] WAKE = 8'(`BDI_WAKE_CYC);
   localparam logic [7:0] GTS = 8'(`BDI_GTS_CYC);
   localparam logic [3:0] CMP = 4'(`BDI_CMP_CYC);

   bdi_state_t q;
   bdi_state_t d;
   logic [11:0] pins;
   logic tx, gate, guard, standby_select_low, en, ioUv, vbatUv, vccUv, lowPow, wakeAny, txOn, mism;
   logic [15:0] status_shift_register;
   logic [31:0] rd;

   function automatic logic [7:0] wakeStep(input logic lvl, input logic [7:0] cnt);
      wakeStep = !lvl ? 8'h00 : (cnt == WAKE ? cnt : cnt + 8'h01);
   endfunction : wakeStep

   function automatic logic isLowPow(input bdi_mode_t m);
      isLowPow = (m != MD_FULL) && (m != MD_LISTEN);
   endfunction : isLowPow

   ////////////////////////////////////////////////////////////////////////////
   // input capture
   assign pins = {vccOk, vbatOk, ioSupplyOk, wakeRemote, wakeLocal, busData, busIdle,
                  modeSelect, standbySelectLow, guardianGate, transmitGateLow, txData};

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.in1 = pins; // RULE22
      d.in2 = q.in1;
      ioUv = !q.in2[`BDI_IN_IOOK]; // RULE15
      vbatUv = !q.in2[`BDI_IN_VBATOK];
      vccUv = !q.in2[`BDI_IN_VCCOK];
      lowPow = isLowPow(q.mode);
      // io supply loss substitutes default input levels
      tx = ioUv ? 1'b0 : q.in2[`BDI_IN_TX]; // RULE19
      gate = ioUv ? 1'b1 : q.in2[`BDI_IN_GATE]; // RULE19
      guard = ioUv ? 1'b0 : q.in2[`BDI_IN_GUARD]; // RULE5
      standby_select_low = ioUv ? 1'b0 : q.in2[`BDI_IN_STANDBY_SELECT_LOW]; // RULE10
      en = ioUv ? 1'b0 : q.in2[`BDI_IN_EN]; // RULE10

      // mode select filter
      if ({standby_select_low, en} != q.selCand) begin // RULE11
         d.selCand = {standby_select_low, en};
         d.filtCnt = 8'h00;
      end else if (q.filtCnt < FILT - 8'h01) begin
         d.filtCnt = q.filtCnt + 8'h01;
      end else begin
         d.selStable = q.selCand; // RULE21
      end

      // wake detection, all modes
      d.wakeLCnt = wakeStep(q.in2[`BDI_IN_WAKEL], q.wakeLCnt); // RULE13
      d.wakeRCnt = wakeStep(q.in2[`BDI_IN_WAKER], q.wakeRCnt); // RULE13
      if (q.ctrl[`BDI_CTRL_CLR_WAKE]) begin
         d.wakeLoc = 1'b0;
         d.wakeRem = 1'b0;
      end
      if (q.wakeLCnt == WAKE - 8'h01 && q.in2[`BDI_IN_WAKEL]) begin // RULE14
         d.wakeLoc = 1'b1;
      end
      if (q.wakeRCnt == WAKE - 8'h01 && q.in2[`BDI_IN_WAKER]) begin // RULE14
         d.wakeRem = 1'b1;
      end
      wakeAny = q.wakeLoc || q.wakeRem;

      // mode machine
      d.gtsCnt = 8'h00;
      case (q.selStable) // RULE12
         2'b11: begin
            d.mode = MD_FULL;
         end
         2'b10: begin
            d.mode = MD_LISTEN;
         end
         2'b01: begin
            if (wakeAny) begin
               d.mode = MD_STANDBY;
            end else if (q.mode == MD_SLEEP) begin
               d.mode = MD_SLEEP;
            end else if (q.mode != MD_GTS) begin
               d.mode = MD_GTS;
            end else if (q.gtsCnt < GTS - 8'h01) begin
               d.gtsCnt = q.gtsCnt + 8'h01;
            end else begin
               d.mode = MD_SLEEP;
            end
         end
         default: begin
            d.mode = MD_STANDBY;
         end
      endcase

      // transmit gating
      txOn = (q.mode == MD_FULL) && !gate && guard; // RULE6 RULE7 RULE3 RULE20
      d.drvEn = txOn; // RULE8
      d.drvData = txOn && tx; // RULE8

      // bus failure comparison
      mism = q.drvEn && (q.in2[`BDI_IN_IDLE] || (q.in2[`BDI_IN_DATA] != q.drvData));
      if (q.mode == MD_FULL && q.ctrl[`BDI_CTRL_CMP_EN] && mism) begin // RULE17
         d.mmCnt = (q.mmCnt == CMP) ? q.mmCnt : q.mmCnt + 4'h1;
      end else begin
         d.mmCnt = 4'h0;
      end
      if (q.ctrl[`BDI_CTRL_CLR_BERR]) begin
         d.busErr = 1'b0;
      end
      if (q.mmCnt == CMP - 4'h1 && d.mmCnt == CMP) begin // RULE16
         d.busErr = 1'b1;
      end

      // receive and activity outputs
      if (ioUv) begin
         d.rxd = 1'b0;
         d.act = 1'b0; // RULE5
      end else if (lowPow) begin
         d.rxd = !wakeAny; // RULE4 RULE1
         d.act = !wakeAny; // RULE4
      end else begin
         d.rxd = q.in2[`BDI_IN_IDLE] || q.in2[`BDI_IN_DATA]; // RULE2
         d.act = q.in2[`BDI_IN_IDLE]; // RULE9
      end
      d.flt = !(ioUv || vbatUv || vccUv || q.busErr); // RULE10 RULE15 RULE16
      d.regulator_control_out = (q.mode != MD_SLEEP);

      // register bus, write channel
      d.ctrl[`BDI_CTRL_CLR_WAKE] = 1'b0;
      d.ctrl[`BDI_CTRL_CLR_BERR] = 1'b0;
      d.awready = s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid;
      d.wready = d.awready;
      if (q.awready) begin
         d.bvalid = 1'b1;
         d.bresp = `BDI_RESP_OKAY;
         if (s_axi_awaddr == `BDI_ADDR_CTRL) begin
            if (s_axi_wstrb[0]) begin
               d.ctrl = s_axi_wdata[2:0];
            end
         end else if (s_axi_awaddr != `BDI_ADDR_STATUS && s_axi_awaddr != `BDI_ADDR_SIR) begin
            d.bresp = `BDI_RESP_SLVERR;
         end
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // register bus, read channel
      status_shift_register = ~{1'b0, standby_select_low, en, q.wakeLoc, !d.flt, ioUv, vccUv, vbatUv, 3'h0,
              q.busErr, 1'b0, 1'b0, q.wakeRem, q.wakeLoc}; // RULE18
      status_shift_register[15] = ^status_shift_register[14:0];
      case (s_axi_araddr)
         `BDI_ADDR_STATUS: begin
            rd = {24'h000000, vccUv, vbatUv, ioUv, q.busErr, wakeAny, q.mode};
         end
         `BDI_ADDR_CTRL: begin
            rd = {29'h00000000, q.ctrl};
         end
         `BDI_ADDR_SIR: begin
            rd = {16'h0000, status_shift_register}; // RULE18
         end
         default: begin
            rd = 32'h00000000;
         end
      endcase
      d.arready = s_axi_arvalid && !q.arready && !q.rvalid;
      if (q.arready) begin
         d.rvalid = 1'b1;
         d.rdata = rd;
         d.rresp = (s_axi_araddr > `BDI_ADDR_SIR || s_axi_araddr[1:0] != 2'h0) ?
                   `BDI_RESP_SLVERR : `BDI_RESP_OKAY;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.mode <= MD_STANDBY; // RULE23
         q.ctrl <= `BDI_CTRL_RST;
         q.rxd <= 1'b1;
         q.act <= 1'b1;
         q.regulator_control_out <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rxDataOut = q.rxd;
   assign activityLowOut = q.act;
   assign faultLowOut = q.flt;
   assign regulatorControlOut = q.regulator_control_out;
   assign busDriveEn = q.drvEn;
   assign busDriveData = q.drvData;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence gtsHeld;
      q.mode == MD_GTS && q.selStable == 2'b01 && !(q.wakeLoc || q.wakeRem);
   endsequence

   lowpow_tx_a: assert property (isLowPow(q.mode) |=> !busDriveEn) // RULE3
      else $error("transmitter active in low power mode");
   guard_block_a: assert property (q.in2[`BDI_IN_GUARD] == 1'b0 |=> !busDriveEn) // RULE6
      else $error("transmitter active with guardian gate low");
   tx_data_a: assert property (q.mode == MD_FULL && !q.in2[`BDI_IN_GATE] && q.in2[`BDI_IN_GUARD]
      && q.in2[`BDI_IN_IOOK] |=> busDriveEn && busDriveData == $past(q.in2[`BDI_IN_TX])) // RULE8
      else $error("transmit data not passed to bus");
   rx_idle_a: assert property (!isLowPow(q.mode) && q.in2[`BDI_IN_IOOK] && q.in2[`BDI_IN_IDLE]
      |=> rxDataOut && activityLowOut) // RULE2
      else $error("idle bus not shown as idle");
   rx_data0_a: assert property (!isLowPow(q.mode) && q.in2[`BDI_IN_IOOK] && !q.in2[`BDI_IN_IDLE]
      && !q.in2[`BDI_IN_DATA] |=> !rxDataOut && !activityLowOut) // RULE9
      else $error("data_0 not shown on receive outputs");
   wake_out_a: assert property (isLowPow(q.mode) && q.in2[`BDI_IN_IOOK] && (q.wakeLoc || q.wakeRem)
      |=> !rxDataOut && !activityLowOut) // RULE4
      else $error("wake flag not shown in low power");
   io_loss_a: assert property (!q.in2[`BDI_IN_IOOK] |=> !faultLowOut && !activityLowOut) // RULE10
      else $error("io supply loss not forcing outputs low");
   gts_sleep_a: assert property (gtsHeld [*8] |-> ##[0:30] q.mode == MD_SLEEP) // RULE12
      else $error("sleep entry did not reach deep sleep");
   filt_hold_a: assert property (q.selStable != $past(q.selStable) |-> q.filtCnt == FILT - 8'h01) // RULE11
      else $error("mode select passed filter early");
   berr_mode_a: assert property ($rose(q.busErr) |-> $past(q.mode) == MD_FULL) // RULE17
      else $error("bus error raised outside full operation");
endmodule : bdi_top

// file: inc/bdi_cfg.svh
`ifndef BDI_CFG_SVH
`define BDI_CFG_SVH
// register map
`define BDI_ADDR_STATUS 4'h0
`define BDI_ADDR_CTRL 4'h4
`define BDI_ADDR_SIR 4'h8
`define BDI_CTRL_CLR_WAKE 0
`define BDI_CTRL_CLR_BERR 1
`define BDI_CTRL_CMP_EN 2
`define BDI_CTRL_RST 3'h4
`define BDI_RESP_OKAY 2'h0
`define BDI_RESP_SLVERR 2'h2
// input bit positions in the synchroniser vector
`define BDI_IN_TX 0
`define BDI_IN_GATE 1
`define BDI_IN_GUARD 2
`define BDI_IN_STANDBY_SELECT_LOW 3
`define BDI_IN_EN 4
`define BDI_IN_IDLE 5
`define BDI_IN_DATA 6
`define BDI_IN_WAKEL 7
`define BDI_IN_WAKER 8
`define BDI_IN_IOOK 9
`define BDI_IN_VBATOK 10
`define BDI_IN_VCCOK 11
`define BDI_IN_W 12
// timing
`define BDI_CLK_NS 10
`define BDI_FILT_NS 1000
`define BDI_FILT_CYC ((`BDI_FILT_NS + `BDI_CLK_NS - 1) / `BDI_CLK_NS)
`define BDI_WAKE_NS 500
`define BDI_WAKE_CYC ((`BDI_WAKE_NS + `BDI_CLK_NS - 1) / `BDI_CLK_NS)
`define BDI_GTS_NS 200
`define BDI_GTS_CYC ((`BDI_GTS_NS + `BDI_CLK_NS - 1) / `BDI_CLK_NS)
`define BDI_CMP_CYC 4
`endif

// file: inc/bdi_pkg.sv
package bdi_pkg;
   typedef enum logic [2:0] {MD_FULL, MD_LISTEN, MD_STANDBY, MD_GTS, MD_SLEEP} bdi_mode_t;
   typedef struct packed {
      logic [11:0] in1;
      logic [11:0] in2;
      logic [1:0] selCand;
      logic [1:0] selStable;
      logic [7:0] filtCnt;
      bdi_mode_t mode;
      logic [7:0] gtsCnt;
      logic [7:0] wakeLCnt;
      logic [7:0] wakeRCnt;
      logic wakeLoc;
      logic wakeRem;
      logic [3:0] mmCnt;
      logic busErr;
      logic [2:0] ctrl;
      logic rxd;
      logic act;
      logic flt;
      logic regulator_control_out;
      logic drvEn;
      logic drvData;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } bdi_state_t;
endpackage : bdi_pkg

// file: test/bdi_bus_model.sv
`timescale 1ns/1ps
// far-side bus: echoes the driven bit, or carries another node's traffic
module bdi_bus_model (
   input wire logic clk_sys,
   input wire logic busDriveEn,
   input wire logic busDriveData,
   input wire logic extActive,
   input wire logic extData,
   input wire logic corrupt,
   output logic busIdle,
   output logic busData
);
   logic lastQ = 1'b0;
   always_ff @(posedge clk_sys) begin
      lastQ <= busData;
   end
   always_comb begin
      if (busDriveEn) begin
         busIdle = 1'b0;
         busData = busDriveData ^ corrupt;
      end else if (extActive) begin
         busIdle = 1'b0;
         busData = extData;
      end else begin
         // idle bus carries no data: show a toggling value
         busIdle = 1'b1;
         busData = ~lastQ;
      end
   end
endmodule : bdi_bus_model

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import bdi_pkg::*;
   logic clk_sys, nrst, txData, transmitGateLow, guardianGate, standbySelectLow, modeSelect;
   logic busIdle, busData, wakeLocal, wakeRemote, ioSupplyOk, extActive, extData, corrupt;
   logic vbatOk, vccOk;
   logic rxDataOut, activityLowOut, faultLowOut, regulatorControlOut, busDriveEn, busDriveData;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, rr;
   int error_cnt = 0;
   int checks = 0;
   bdi_top uut (.clk_sys(clk_sys), .nrst(nrst), .txData(txData), .transmitGateLow(transmitGateLow),
      .guardianGate(guardianGate), .standbySelectLow(standbySelectLow), .modeSelect(modeSelect),
      .busIdle(busIdle), .busData(busData), .wakeLocal(wakeLocal), .wakeRemote(wakeRemote),
      .ioSupplyOk(ioSupplyOk), .vbatOk(vbatOk), .vccOk(vccOk), .rxDataOut(rxDataOut),
      .activityLowOut(activityLowOut), .faultLowOut(faultLowOut), .regulatorControlOut(regulatorControlOut),
      .busDriveEn(busDriveEn), .busDriveData(busDriveData), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   bdi_bus_model bus (.clk_sys(clk_sys), .busDriveEn(busDriveEn), .busDriveData(busDriveData),
      .extActive(extActive), .extData(extData), .corrupt(corrupt), .busIdle(busIdle), .busData(busData));
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (e !== g) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic tmo();
      error_cnt++;
      $display("wrong value bus wait expected answer seen none");
      print_verdict();
   endtask : tmo
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (awready !== 1'b1 && n < 50);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      rr = bresp;
      bready <= 1'b0;
      if (n >= 50) tmo();
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
      if (n >= 50) tmo();
      @(posedge clk_sys);
   endtask : rd
   task automatic pins(input logic g, input logic bg, input logic t);
      transmitGateLow <= g;
      guardianGate <= bg;
      txData <= t;
      // bus echo needs two sync flops after the driver flop, then the output flop
      repeat (8) @(posedge clk_sys);
   endtask : pins
   task automatic sel(input logic s, input logic e);
      standbySelectLow <= s;
      modeSelect <= e;
      repeat (170) @(posedge clk_sys);
   endtask : sel
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {nrst, txData, guardianGate, standbySelectLow, modeSelect, wakeLocal, wakeRemote} = '0;
      {extActive, extData, corrupt, awvalid, wvalid, bready, arvalid, rready} = '0;
      {transmitGateLow, ioSupplyOk, vbatOk, vccOk} = 4'hF;
      {awaddr, araddr, wdata} = '0;
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (5) @(posedge clk_sys);
      rd(4'h0);
      chk("reset mode", 32'h2, {29'h0, rv[2:0]});
      chk("standby rx act", 32'h3, {rxDataOut, activityLowOut});
      $display("test reset done");
      sel(1'b1, 1'b1);
      rd(4'h0);
      chk("full mode", 32'h0, {29'h0, rv[2:0]});
      pins(1'b0, 1'b1, 1'b0);
      chk("send data0", 32'h2, {busDriveEn, busDriveData});
      chk("rx act data0", 32'h0, {rxDataOut, activityLowOut});
      pins(1'b0, 1'b1, 1'b1);
      chk("send data1", 32'h3, {busDriveEn, busDriveData});
      chk("rx act data1", 32'h2, {rxDataOut, activityLowOut});
      pins(1'b0, 1'b0, 1'b1);
      chk("guardian block", 32'h3, {busDriveEn, rxDataOut, activityLowOut});
      corrupt <= 1'b1;
      pins(1'b0, 1'b1, 1'b0);
      repeat (20) @(posedge clk_sys);
      rd(4'h0);
      chk("bus error", 32'h1, {31'h0, rv[4]});
      chk("fault pin", 32'h0, {31'h0, faultLowOut});
      corrupt <= 1'b0;
      pins(1'b1, 1'b1, 1'b0);
      wr(4'h4, 32'h6);
      rd(4'h0);
      chk("error cleared", 32'h0, {31'h0, rv[4]});
      $display("test full done");
      standbySelectLow <= 1'b0;
      repeat (30) @(posedge clk_sys);
      sel(1'b1, 1'b1);
      rd(4'h0);
      chk("spike ignored", 32'h0, {29'h0, rv[2:0]});
      sel(1'b1, 1'b0);
      rd(4'h0);
      chk("listen mode", 32'h1, {29'h0, rv[2:0]});
      extActive <= 1'b1;
      pins(1'b0, 1'b1, 1'b0);
      chk("listen tx off", 32'h0, {31'h0, busDriveEn});
      chk("listen rx", 32'h0, {rxDataOut, activityLowOut});
      extActive <= 1'b0;
      $display("test listen done");
      sel(1'b0, 1'b1);
      rd(4'h0);
      chk("sleep mode", 32'h4, {29'h0, rv[2:0]});
      chk("sleep outs", 32'h0, {busDriveEn, regulatorControlOut});
      wakeRemote <= 1'b1;
      repeat (10) @(posedge clk_sys);
      wakeRemote <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(4'h0);
      chk("wake glitch", 32'h0, {31'h0, rv[3]});
      wakeLocal <= 1'b1;
      repeat (70) @(posedge clk_sys);
      wakeLocal <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(4'h0);
      chk("wake flag", 32'h1, {31'h0, rv[3]});
      chk("wake rx act", 32'h0, {rxDataOut, activityLowOut});
      wr(4'h4, 32'h5);
      sel(1'b0, 1'b0);
      rd(4'h0);
      chk("standby mode", 32'h2, {29'h0, rv[2:0]});
      chk("idle rx act", 32'h3, {rxDataOut, activityLowOut});
      $display("test low power done");
      ioSupplyOk <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("io loss", 32'h0, {activityLowOut, faultLowOut});
      ioSupplyOk <= 1'b1;
      vbatOk <= 1'b0;
      vccOk <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(4'h0);
      chk("supply uv bits", 32'h3, {30'h0, rv[7:6]});
      chk("supply uv fault", 32'h0, {31'h0, faultLowOut});
      vbatOk <= 1'b1;
      vccOk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("supply ok fault", 32'h1, {31'h0, faultLowOut});
      rd(4'hC);
      chk("unmapped resp", 32'h2, {30'h0, rr});
      wr(4'hC, 32'h0);
      chk("unmapped wr resp", 32'h2, {30'h0, rr});
      $display("test supply done");
      print_verdict();
   end
   initial begin
      #900000;
      tmo();
   end
endmodule : testbench
